//--- power_save_regs.svh
// Constants for the power-save mode controller
// Assumes inclusion from the package and design files by bare name
`ifndef POWER_SAVE_REGS_SVH
`define POWER_SAVE_REGS_SVH
// Operand of the power-save instruction
`define PSAV_OP_SLEEP       1'b0
`define PSAV_OP_IDLE        1'b1
// Unlock key values and their width
`define UNLOCK_KEY_W        8
`define UNLOCK_KEY1         8'h55
`define UNLOCK_KEY2         8'haa
// Cycles the unlock stays open after the second key
`define UNLOCK_WIN          4'h5
// Wake-cause field positions
`define WAKE_POR            0
`define WAKE_MASTER_CLEAR_RESET_PIN           1
`define WAKE_RTC            2
`define WAKE_INT0           3
`define WAKE_DEEP_SLEEP_WATCHDOG          4
`define WAKE_ULTRA_LOW_POWER_WAKEUP          5
`define WAKE_W              6
`define WAKE_RESET          6'h00
`endif

//--- power_save_pkg.sv
// Types shared by the power-save mode controller
// Assumes the constants header is on the include path
`include "power_save_regs.svh"
package power_save_pkg;
	// Power state of the core
	typedef enum logic [1:0] {
		ST_RUN,
		ST_IDLE,
		ST_SLEEP,
		ST_DEEP
	} pwr_state_e;
	// Deep-sleep wake sources
	typedef struct packed {
		logic ulp_wakeup;
		logic ds_watchdog;
		logic ext_int0;
		logic calendar_alarm;
		logic master_clear;
		logic power_on;
	} wake_src_s;
	// Clock and oscillator controls
	typedef struct packed {
		logic cpu_clk_en;
		logic sys_clk_en;
		logic periph_clk_en;
		logic low_power_rc_oscillator_en;
		logic calendar_clk_en;
	} clk_ctl_s;
endpackage

//--- unlock_seq.sv
// Two-key unlock detector gating set writes to the deep-sleep arm bit; clears are not gated
// Assumes key writes come from the core on the same clock
`timescale 1ns/1ps
`include "power_save_regs.svh"
module unlock_seq (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic                     key_wr,
	input  wire logic [`UNLOCK_KEY_W-1:0] key_data,
	input  wire logic                     consume,
	output logic                          unlocked
);
	logic       got1_reg;   // First key seen
	logic       got1_next;
	logic [3:0] win_reg;    // Open-window count
	logic [3:0] win_next;

	////////////////////////////////////////////////////////////
	// Next state of the key matcher
	always_comb begin
		got1_next = got1_reg;
		win_next  = win_reg;
		if (win_reg != 4'h0) begin
			win_next = win_reg - 4'h1;
		end
		if (consume) begin
			win_next = 4'h0;
		end
		if (key_wr) begin
			if (got1_reg && key_data == `UNLOCK_KEY2) begin
				win_next  = `UNLOCK_WIN;
				got1_next = 1'b0;
			end else begin
				got1_next = (key_data == `UNLOCK_KEY1);
			end
		end
	end

	// Register the matcher
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			got1_reg <= 1'b0;
			win_reg  <= 4'h0;
		end else begin
			got1_reg <= got1_next;
			win_reg  <= win_next;
		end
	end

	assign unlocked = (win_reg != 4'h0);
endmodule // unlock_seq

//--- power_save_mode_control.sv
// Power-save mode controller: Idle, Sleep and Deep Sleep sequencing
// Assumes core strobes are on clk; wake pins are asynchronous
//
// Function
// - Idle halts CPU, system clock keeps running
// - Idle entry clears the general watchdog count
// - Peripherals run in Idle unless disabled
// - Watchdog or clock monitor keeps LOW_POWER_RC_OSCILLATOR on
// - Idle exits on interrupt, reset, watchdog timeout
// - Wake regates CPU clock, resumes immediately
// - Interrupt during instruction pends, then wakes from Idle or Sleep
// - Deep Sleep exits on six listed sources
// - Calendar clock keeps counting in Deep Sleep
// - Separate deep-sleep brown-out and watchdog
// - Deep Sleep needs unlocked arm bit, sleep
// - Arm bit clears on Deep Sleep exit
// - Arm bit set clears wake-cause register
`timescale 1ns/1ps
`include "power_save_regs.svh"
module power_save_mode_control (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic                     psav_exec,
	input  wire logic                     psav_operand,
	input  wire logic                     irq_pending,
	input  wire logic                     wdt_timeout,
	input  wire logic                     wdt_enable,
	input  wire logic                     fail_safe_clock_monitor_enable,
	input  wire logic                     periph_disable,
	input  wire logic                     key_wr,
	input  wire logic [`UNLOCK_KEY_W-1:0] key_data,
	input  wire logic                     arm_set_req,
	input  wire logic                     arm_clr_req,
	input  wire logic                     power_on_event,
	input  wire logic                     master_clear_reset_pin_pin,
	input  wire logic                     calendar_alarm_pin,
	input  wire logic                     ext_int0_pin,
	input  wire logic                     ds_watchdog_timeout,
	input  wire logic                     ulp_wakeup_pin,
	input  wire logic                     ds_brownout_enable,
	input  wire logic                     ds_watchdog_enable,
	output power_save_pkg::clk_ctl_s      clk_ctl,
	output logic                          wdt_clear,
	output logic                          resume_pulse,
	output logic                          deep_sleep_arm_bit,
	output power_save_pkg::wake_src_s     deep_sleep_wake_cause,
	output power_save_pkg::pwr_state_e    pwr_state,
	output logic                          ds_brownout_active,
	output logic                          ds_watchdog_active
);
	////////////////////////////////////////////////////////////
	// Synchronise asynchronous wake pins (two flops each)
	power_save_pkg::wake_src_s  pin_raw;    // Raw wake pins
	power_save_pkg::wake_src_s  sync1_reg;  // First stage
	power_save_pkg::wake_src_s  sync2_reg;  // Second stage
	assign pin_raw = '{ulp_wakeup:     ulp_wakeup_pin,
	                   ds_watchdog:    ds_watchdog_timeout,
	                   ext_int0:       ext_int0_pin,
	                   calendar_alarm: calendar_alarm_pin,
	                   master_clear:   master_clear_reset_pin_pin,
	                   power_on:       power_on_event};

	// Synchroniser flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
		end
	end

	////////////////////////////////////////////////////////////
	// Unlock gate for the arm bit
	logic unlocked;     // Arm-bit write window open
	logic arm_take;     // Arm bit write accepted
	assign arm_take = arm_set_req && unlocked;

	unlock_seq u_unlock (
		.clk      (clk),
		.reset_n  (reset_n),
		.key_wr   (key_wr),
		.key_data (key_data),
		.consume  (arm_take),
		.unlocked (unlocked)
	);

	////////////////////////////////////////////////////////////
	// Power state machine
	power_save_pkg::pwr_state_e state_reg;   // Current mode
	power_save_pkg::pwr_state_e state_next;
	logic                       arm_reg;     // Deep-sleep arm bit
	logic                       arm_next;
	power_save_pkg::wake_src_s  cause_reg;   // Wake-cause flags
	power_save_pkg::wake_src_s  cause_next;
	logic                       wdtc_reg;    // Watchdog clear pulse
	logic                       wdtc_next;
	logic                       res_reg;     // Resume pulse
	logic                       res_next;
	logic                       ds_wake;     // Any deep-sleep exit source

	assign ds_wake = |sync2_reg;

	// Next-state logic
	always_comb begin
		state_next = state_reg;
		arm_next   = arm_reg;
		cause_next = cause_reg;
		wdtc_next  = 1'b0;
		res_next   = 1'b0;
		// Software arm and disarm; only software arms
		if (arm_take) begin
			arm_next   = 1'b1;
			cause_next = '0;
		end else if (arm_clr_req) begin
			arm_next = 1'b0;
		end
		unique case (state_reg)
			power_save_pkg::ST_RUN: begin
				// Operand latched at execution
				if (psav_exec) begin
					if (psav_operand == `PSAV_OP_IDLE) begin
						state_next = power_save_pkg::ST_IDLE;
						wdtc_next  = 1'b1;
					end else if (arm_reg) begin
						state_next = power_save_pkg::ST_DEEP;
					end else begin
						state_next = power_save_pkg::ST_SLEEP;
					end
				end
			end
			power_save_pkg::ST_IDLE, power_save_pkg::ST_SLEEP: begin
				// Coincident interrupt still pending wakes here
				if (irq_pending || wdt_timeout) begin
					state_next = power_save_pkg::ST_RUN;
					res_next   = 1'b1;
				end
			end
			power_save_pkg::ST_DEEP: begin
				if (ds_wake) begin
					state_next = power_save_pkg::ST_RUN;
					res_next   = 1'b1;
					arm_next   = 1'b0;
					cause_next = cause_reg | sync2_reg;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= power_save_pkg::ST_RUN;
			arm_reg   <= 1'b0;
			cause_reg <= `WAKE_RESET;
			wdtc_reg  <= 1'b0;
			res_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			arm_reg   <= arm_next;
			cause_reg <= cause_next;
			wdtc_reg  <= wdtc_next;
			res_reg   <= res_next;
		end
	end

	////////////////////////////////////////////////////////////
	// Clock controls from the mode
	always_comb begin
		clk_ctl.cpu_clk_en      = (state_reg == power_save_pkg::ST_RUN);
		clk_ctl.sys_clk_en      = (state_reg == power_save_pkg::ST_RUN) ||
		                          (state_reg == power_save_pkg::ST_IDLE);
		clk_ctl.periph_clk_en   = clk_ctl.sys_clk_en && !periph_disable;
		clk_ctl.low_power_rc_oscillator_en         = wdt_enable || fail_safe_clock_monitor_enable;
		clk_ctl.calendar_clk_en = 1'b1;
	end

	assign wdt_clear             = wdtc_reg;
	assign resume_pulse          = res_reg;
	assign deep_sleep_arm_bit    = arm_reg;
	assign deep_sleep_wake_cause = cause_reg;
	assign pwr_state             = state_reg;
	// Deep-sleep monitors independent of the standard ones
	assign ds_brownout_active    = ds_brownout_enable && (state_reg == power_save_pkg::ST_DEEP);
	assign ds_watchdog_active    = ds_watchdog_enable && (state_reg == power_save_pkg::ST_DEEP);

	////////////////////////////////////////////////////////////
	// Assertions
	sequence idle_entry_s;
		state_reg == power_save_pkg::ST_RUN && psav_exec && psav_operand == `PSAV_OP_IDLE;
	endsequence
	sequence wake_s;
		(state_reg == power_save_pkg::ST_IDLE || state_reg == power_save_pkg::ST_SLEEP)
			&& (irq_pending || wdt_timeout);
	endsequence

	idle_cpu_halt_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg == power_save_pkg::ST_IDLE |-> !clk_ctl.cpu_clk_en && clk_ctl.sys_clk_en)
		else $error("cpu clock not halted in idle");
	idle_wdt_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		idle_entry_s |=> wdt_clear && state_reg == power_save_pkg::ST_IDLE)
		else $error("watchdog not cleared on idle entry");
	periph_run_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg == power_save_pkg::ST_IDLE && !periph_disable |-> clk_ctl.periph_clk_en)
		else $error("peripherals stopped in idle");
	low_power_rc_oscillator_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
		(wdt_enable || fail_safe_clock_monitor_enable) |-> clk_ctl.low_power_rc_oscillator_en)
		else $error("low_power_rc_oscillator off while watchdog enabled");
	idle_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
		wake_s |=> state_reg == power_save_pkg::ST_RUN)
		else $error("no wake from idle");
	resume_now_a: assert property (@(posedge clk) disable iff (!reset_n)
		wake_s |=> resume_pulse && clk_ctl.cpu_clk_en)
		else $error("cpu not resumed on wake");
	pend_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg == power_save_pkg::ST_RUN && psav_exec && !arm_reg && irq_pending ##1 irq_pending
			|=> state_reg == power_save_pkg::ST_RUN)
		else $error("coincident interrupt lost");
	deep_exit_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg == power_save_pkg::ST_DEEP && ds_wake |=> state_reg == power_save_pkg::ST_RUN)
		else $error("deep sleep not exited");
	cal_run_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg == power_save_pkg::ST_DEEP |-> clk_ctl.calendar_clk_en)
		else $error("calendar clock stopped");
	ds_monitor_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg != power_save_pkg::ST_DEEP |-> !ds_brownout_active && !ds_watchdog_active)
		else $error("deep sleep monitor active outside deep sleep");
	deep_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(state_reg == power_save_pkg::ST_DEEP) |-> $past(arm_reg) && $past(psav_exec))
		else $error("deep sleep entered without arm");
	arm_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg == power_save_pkg::ST_DEEP && ds_wake |=> !deep_sleep_arm_bit)
		else $error("arm bit not cleared on exit");
	cause_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		arm_take |=> deep_sleep_wake_cause == `WAKE_RESET)
		else $error("wake cause not cleared on arm");
	mode_select_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg == power_save_pkg::ST_RUN && psav_exec && psav_operand == `PSAV_OP_SLEEP && !arm_reg
			|=> state_reg == power_save_pkg::ST_SLEEP)
		else $error("sleep operand not honoured");
endmodule // power_save_mode_control

//--- core_model.sv
// Model of the processor core on the far side of the controller
// Assumes the bench pulses raise off the clock edge; state comes from the controller
`timescale 1ns/1ps
module core_model (
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	input  wire logic                       raise,
	input  wire power_save_pkg::pwr_state_e pwr_state,
	output logic                            irq_pending
);
	logic irq_reg;  // Enabled interrupt waiting for service
	logic irq_next; // Next pending value
	logic run_reg;  // State was RUN on the previous edge
	logic run_next; // Next value of run_reg
	////////////////////////////////////////////////////////////////////////////////
	// Interrupt is held until the core is running again and takes it
	always_comb begin
		irq_next = irq_reg;
		run_next = (pwr_state == power_save_pkg::ST_RUN);
		if (raise) begin
			irq_next = 1'b1;
		end else if (!run_reg && run_next) begin
			irq_next = 1'b0;
		end
	end
	// State registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_reg <= 1'b0;
			run_reg <= 1'b1;
		end else begin
			irq_reg <= irq_next;
			run_reg <= run_next;
		end
	end
	assign irq_pending = irq_reg;
endmodule // core_model

//--- tb_power_save_mode_control.sv
// Self-checking bench for the power-save mode controller
// Assumes the design and core model files; inputs driven at the falling edge
`timescale 1ns/1ps
module tb_power_save_mode_control;
	logic                         clk = 1'b0;     // 100 MHz clock
	logic                         reset_n = 1'b0; // Active-low reset
	logic                         psav_exec = 1'b0, psav_operand = 1'b0, irq_pending, irq_raise = 1'b0;
	logic                         wdt_timeout = 1'b0, wdt_enable = 1'b0, fail_safe_clock_monitor_enable = 1'b0;
	logic                         periph_disable = 1'b0, key_wr = 1'b0, arm_set_req = 1'b0, arm_clr_req = 1'b0;
	logic [7:0]                   key_data = 8'h00;
	logic [5:0]                   wk = 6'h00;     // Wake pins, cause bit order
	logic                         ds_brownout_enable = 1'b0, ds_watchdog_enable = 1'b0;
	power_save_pkg::clk_ctl_s     clk_ctl;
	logic                         wdt_clear, resume_pulse, arm, dsbo, dswd;
	power_save_pkg::wake_src_s    cause;
	power_save_pkg::pwr_state_e   pwr_state;
	logic [35:0]                  q [$];          // Expected {mask, value} notes
	logic [35:0]                  rec;
	logic [17:0]                  obs;
	logic [2:0]                   last;
	logic                         mon_on = 1'b0;
	logic [4:0]                   mode_ctl;
	int                           fail_count = 0, samples_checked = 0;
	////////////////////////////////////////////////////////////////////////////////
	always #5 clk = ~clk;
	power_save_mode_control DUT (.clk(clk), .reset_n(reset_n), .psav_exec(psav_exec), .psav_operand(psav_operand),
		.irq_pending(irq_pending), .wdt_timeout(wdt_timeout), .wdt_enable(wdt_enable), .fail_safe_clock_monitor_enable(fail_safe_clock_monitor_enable),
		.periph_disable(periph_disable), .key_wr(key_wr), .key_data(key_data), .arm_set_req(arm_set_req),
		.arm_clr_req(arm_clr_req), .power_on_event(wk[0]), .master_clear_reset_pin_pin(wk[1]), .calendar_alarm_pin(wk[2]),
		.ext_int0_pin(wk[3]), .ds_watchdog_timeout(wk[4]), .ulp_wakeup_pin(wk[5]),
		.ds_brownout_enable(ds_brownout_enable), .ds_watchdog_enable(ds_watchdog_enable), .clk_ctl(clk_ctl),
		.wdt_clear(wdt_clear), .resume_pulse(resume_pulse), .deep_sleep_arm_bit(arm),
		.deep_sleep_wake_cause(cause), .pwr_state(pwr_state), .ds_brownout_active(dsbo),
		.ds_watchdog_active(dswd));
	core_model core (.clk(clk), .reset_n(reset_n), .raise(irq_raise), .pwr_state(pwr_state),
		.irq_pending(irq_pending));
	////////////////////////////////////////////////////////////////////////////////
	// Compare one seen value with its expected value
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic results();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Note an expected state change; clock mask cm picks the enables that matter
	task automatic note(input power_save_pkg::pwr_state_e st, input logic [4:0] ctl, input logic [4:0] cm,
		input logic wc, input logic rs, input logic rm, input logic a, input logic [5:0] c);
		logic deep;
		deep = (st == power_save_pkg::ST_DEEP);
		q.push_back({{2'b11, cm, 1'b1, rm, 1'b1, 6'h3f, 2'b11},
			{st, ctl, wc, rs, a, c, ds_brownout_enable & deep, ds_watchdog_enable & deep}});
	endtask
	// Bounded wait until every note has been matched
	task automatic wait_empty();
		for (int n = 0; n < 40 && q.size() != 0; n++) @(negedge clk);
		if (q.size() != 0) begin
			fail_count++;
			results();
		end
	endtask
	// One-cycle strobes, raised and lowered at falling edges
	task automatic psav(input logic op);
		@(negedge clk) {psav_exec, psav_operand} = {1'b1, op};
		@(negedge clk) psav_exec = 1'b0;
	endtask
	task automatic key(input logic [7:0] d);
		@(negedge clk) {key_wr, key_data} = {1'b1, d};
		@(negedge clk) key_wr = 1'b0;
	endtask
	task automatic arm_set();
		@(negedge clk) arm_set_req = 1'b1;
		@(negedge clk) arm_set_req = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Watcher: each change of state or arm bit takes the oldest note
	always @(negedge clk) begin
		obs = {pwr_state, clk_ctl, wdt_clear, resume_pulse, arm, cause, dsbo, dswd};
		if (mon_on && {pwr_state, arm} !== last) begin
			last = {pwr_state, arm};
			if (q.size() == 0) begin
				check({2'b01, obs}, {2'b10, obs});
			end else begin
				rec = q.pop_front();
				check({2'b00, obs & rec[35:18]}, {2'b00, rec[17:0] & rec[35:18]});
			end
		end
	end
	// Hang guard
	initial begin
		#1000000;
		fail_count++;
		results();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'h7849c372));
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		last = {pwr_state, arm};
		mon_on = 1'b1;
		// Idle woken by interrupt, watchdog, coincident interrupt, reset; then Sleep
		for (int k = 0; k < 5; k++) begin
			{wdt_enable, fail_safe_clock_monitor_enable, periph_disable} = 3'($urandom);
			mode_ctl = {2'b01, ~periph_disable, wdt_enable | fail_safe_clock_monitor_enable, 1'b1};
			if (k == 2) begin
				@(negedge clk) irq_raise = 1'b1;
				@(negedge clk) irq_raise = 1'b0;
			end
			if (k < 4) note(power_save_pkg::ST_IDLE, mode_ctl, 5'h1f, 1'b1, 1'b0, 1'b0, 1'b0, 6'h00);
			else note(power_save_pkg::ST_SLEEP, 5'h01, 5'h11, 1'b0, 1'b0, 1'b0, 1'b0, 6'h00);
			note(power_save_pkg::ST_RUN, 5'h19, 5'h19, 1'b0, k != 3, k < 4, 1'b0, 6'h00);
			psav(k < 4);
			if (k == 0) psav(1'b0);
			if (k == 1) begin
				@(negedge clk) wdt_timeout = 1'b1;
				@(negedge clk) wdt_timeout = 1'b0;
			end else if (k == 3) begin
				@(negedge clk) reset_n = 1'b0;
				repeat (2) @(negedge clk);
				reset_n = 1'b1;
			end else if (k != 2) begin
				@(negedge clk) irq_raise = 1'b1;
				@(negedge clk) irq_raise = 1'b0;
			end
			wait_empty();
		end
		// Deep Sleep through each wake source; software alone starts entry
		for (int i = 0; i < 6; i++) begin
			{ds_brownout_enable, ds_watchdog_enable} = 2'($urandom);
			if (i == 0) begin
				arm_set();
				key(8'h55);
				key(8'haa);
				repeat (8) @(negedge clk);
				arm_set();
				repeat (4) @(negedge clk);
				wait_empty();
				note(power_save_pkg::ST_RUN, 5'h19, 5'h19, 1'b0, 1'b0, 1'b1, 1'b1, 6'h00);
				note(power_save_pkg::ST_RUN, 5'h19, 5'h19, 1'b0, 1'b0, 1'b1, 1'b0, 6'h00);
				key(8'h55);
				key(8'haa);
				arm_set();
				@(negedge clk) arm_clr_req = 1'b1;
				@(negedge clk) arm_clr_req = 1'b0;
				wait_empty();
			end
			note(power_save_pkg::ST_RUN, 5'h19, 5'h19, 1'b0, 1'b0, 1'b1, 1'b1, 6'h00);
			key(8'h55);
			key(8'haa);
			arm_set();
			note(power_save_pkg::ST_DEEP, 5'h01, 5'h11, 1'b0, 1'b0, 1'b0, 1'b1, 6'h00);
			psav(1'b0);
			note(power_save_pkg::ST_RUN, 5'h19, 5'h19, 1'b0, 1'b0, 1'b0, 1'b0, 6'h01 << i);
			@(negedge clk) wk[i] = 1'b1;
			wait_empty();
			wk[i] = 1'b0;
		end
		repeat (4) @(negedge clk);
		results();
	end
endmodule // tb_power_save_mode_control
